// ---- design/sps_pkg.sv ----
// Package of the stepper phase sequencer: register map, fields, encodings.
// Assumes one clock domain and a 32-bit APB register bus.
package sps_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATE      = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK   = 8'h0C;
  localparam logic [7:0] REG_OFF_TIME_A = 8'h10;
  localparam logic [7:0] REG_OFF_TIME_B = 8'h14;
  localparam logic [7:0] REG_STEP_COUNT = 8'h18;

  // Control fields and reset values
  localparam int         CTRL_ENABLE_BIT   = 0;
  localparam logic       CTRL_ENABLE_RESET = 1'b1;
  localparam logic [3:0] INT_MASK_RESET    = 4'h0;

  // State register fields
  localparam int STATE_PHASE_LSB  = 0;
  localparam int STATE_RUN_BIT    = 3;
  localparam int STATE_FAULT_BIT  = 4;
  localparam int STATE_OFF_A_BIT  = 5;
  localparam int STATE_OFF_B_BIT  = 6;
  localparam int STATE_DIR_BIT    = 7;
  localparam int STATE_HALF_BIT   = 8;
  localparam int STATE_DECAY_BIT  = 9;

  // Interrupt status bits
  localparam int INT_W         = 4;
  localparam int INT_STEP_BIT  = 0;
  localparam int INT_FAULT_BIT = 1;
  localparam int INT_TRIP_A    = 2;
  localparam int INT_TRIP_B    = 3;

  // Phase sequence: index 0 is state number 1, the home state
  localparam logic [2:0] PHASE_HOME = 3'h0;
  localparam logic [2:0] HALF_INC   = 3'h1;
  localparam logic [2:0] FULL_INC   = 3'h2;

  // Winding drive codes
  localparam logic [1:0] DRV_OFF = 2'h0;
  localparam logic [1:0] DRV_POS = 2'h1;
  localparam logic [1:0] DRV_NEG = 2'h2;

  // Bridge gate patterns {high1, low1, high2, low2}
  localparam logic [3:0] GATE_NONE = 4'h0;
  localparam logic [3:0] GATE_POS  = 4'h9;
  localparam logic [3:0] GATE_NEG  = 4'h6;
  localparam logic [3:0] GATE_SLOW = 4'h5;

  localparam int          OFF_W          = 16;
  localparam logic [15:0] OFF_TIME_RESET = 16'h0100;

endpackage

// ---- design/sps_current_ctrl.sv ----
// One bridge current controller: constant off-time chopper with decay choice.
// Assumes trip is a synchronous comparator level from the sense resistor.
`timescale 1ns/1ps
module sps_current_ctrl
  import sps_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             bridge_enable,
  input  wire logic [1:0]       drive,
  input  wire logic             decay_slow,
  input  wire logic             trip,
  input  wire logic [OFF_W-1:0] off_time,
  output logic      [3:0]       gate,
  output logic                  off_active
);

  typedef enum logic {CC_ON, CC_OFF} sps_cc_state_type;

  sps_cc_state_type state;
  logic [OFF_W-1:0] off_count;
  logic [3:0]       on_pattern;
  logic [3:0]       next_gate;

  assign off_active = (state == CC_OFF);

  always_comb begin
    case (drive)
      DRV_POS: on_pattern = GATE_POS;
      DRV_NEG: on_pattern = GATE_NEG;
      default: on_pattern = GATE_NONE;
    endcase
  end

  always_comb begin
    if (state == CC_ON) begin
      next_gate = on_pattern;
    end else if (decay_slow) begin
      next_gate = (drive == DRV_OFF) ? GATE_NONE : GATE_SLOW;
    end else begin
      case (drive)
        DRV_POS: next_gate = GATE_NEG;
        DRV_NEG: next_gate = GATE_POS;
        default: next_gate = GATE_NONE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= CC_ON;
      off_count <= '0;
    end else begin
      case (state)
        CC_ON: begin
          if (bridge_enable && trip && drive != DRV_OFF) begin
            state     <= CC_OFF;
            off_count <= off_time;
          end
        end
        CC_OFF: begin
          if (off_count <= OFF_W'(1)) begin
            state <= CC_ON;
          end else begin
            off_count <= off_count - OFF_W'(1);
          end
        end
        default: state <= CC_ON;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate <= GATE_NONE;
    end else begin
      gate <= bridge_enable ? next_gate : GATE_NONE;
    end
  end

  a_slow_decay_gates: assert property (@(posedge pclk) disable iff (!presetn)
    off_active && decay_slow && bridge_enable && drive != DRV_OFF |=> gate == GATE_SLOW)
    else $error("slow decay pattern wrong");

  a_trip_starts_off: assert property (@(posedge pclk) disable iff (!presetn)
    !off_active && bridge_enable && trip && drive != DRV_OFF |=> off_active)
    else $error("trip did not start off time");

  a_off_time_held: assert property (@(posedge pclk) disable iff (!presetn)
    off_active && off_count > OFF_W'(1) |=> off_active && off_count == $past(off_count) - OFF_W'(1))
    else $error("off time cut short");

endmodule

// ---- design/sps_sequencer.sv ----
// Stepper phase sequencer with two chopping bridge controllers and APB registers.
// Assumes all pin inputs are synchronous to pclk; enable pin is open drain.
//
// Summary of operation
// - Sequence moves one step per rising step clock edge, never on falling.
// - Direction high steps clockwise, low steps counterclockwise.
// - Step size high gives half steps, low gives full steps.
// - Decay select high gives slow decay in off phase, low gives fast.
// - Enable low turns off every bridge transistor regardless of other inputs.
// - Sequence reset low forces the home state, state number 1.
// - Each bridge has its own current controller and own off time.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module sps_sequencer
  import sps_pkg::*;
#(
  parameter logic [OFF_W-1:0] OFF_TIME_A_INIT = OFF_TIME_RESET,
  parameter logic [OFF_W-1:0] OFF_TIME_B_INIT = OFF_TIME_RESET
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        step_clock,
  input  wire logic        rotation_direction,
  input  wire logic        step_half,
  input  wire logic        decay_slow,
  input  wire logic        sequence_reset_n,
  input  wire logic        enable_in,
  output logic             enable_out,
  output logic             enable_oe,
  input  wire logic        overcurrent,
  input  wire logic        thermal_fault,
  input  wire logic        trip_a,
  input  wire logic        trip_b,
  output logic      [3:0]  gate_a,
  output logic      [3:0]  gate_b,
  output logic             irq
);

  logic             soft_enable;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] int_event;
  logic [OFF_W-1:0] off_time_network_a;
  logic [OFF_W-1:0] off_time_network_b;
  logic [15:0]      step_count;
  logic [2:0]       phase;
  logic [2:0]       next_phase;
  logic             step_prev;
  logic             step_edge;
  logic             fault_drive;
  logic             fault_prev;
  logic             bridge_enable;
  logic [1:0]       drive_a;
  logic [1:0]       drive_b;
  logic             off_a;
  logic             off_b;
  logic             off_a_prev;
  logic             off_b_prev;
  logic             bus_write;
  logic             bus_setup;

  // Register address decode
  function automatic logic reg_hit(input logic [7:0] addr);
    case (addr)
      REG_CTRL, REG_STATE, REG_INT_STATUS, REG_INT_MASK,
      REG_OFF_TIME_A, REG_OFF_TIME_B, REG_STEP_COUNT: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // Winding drive for each phase index, {bridge A, bridge B}
  function automatic logic [3:0] phase_drive(input logic [2:0] ph);
    case (ph)
      3'h0:    phase_drive = {DRV_POS, DRV_POS};
      3'h1:    phase_drive = {DRV_OFF, DRV_POS};
      3'h2:    phase_drive = {DRV_NEG, DRV_POS};
      3'h3:    phase_drive = {DRV_NEG, DRV_OFF};
      3'h4:    phase_drive = {DRV_NEG, DRV_NEG};
      3'h5:    phase_drive = {DRV_OFF, DRV_NEG};
      3'h6:    phase_drive = {DRV_POS, DRV_NEG};
      default: phase_drive = {DRV_POS, DRV_OFF};
    endcase
  endfunction

  // APB handshake: zero wait states
  assign pready    = 1'b1;
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite && reg_hit(paddr);
  assign pslverr   = psel && penable && !reg_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (bus_setup && !pwrite) begin
      prdata <= '0;
      case (paddr)
        REG_CTRL:       prdata[CTRL_ENABLE_BIT] <= soft_enable;
        REG_STATE: begin
          prdata[STATE_PHASE_LSB +: 3] <= phase;
          prdata[STATE_RUN_BIT]        <= bridge_enable;
          prdata[STATE_FAULT_BIT]      <= fault_drive;
          prdata[STATE_OFF_A_BIT]      <= off_a;
          prdata[STATE_OFF_B_BIT]      <= off_b;
          prdata[STATE_DIR_BIT]        <= rotation_direction;
          prdata[STATE_HALF_BIT]       <= step_half;
          prdata[STATE_DECAY_BIT]      <= decay_slow;
        end
        REG_INT_STATUS: prdata[INT_W-1:0] <= int_status;
        REG_INT_MASK:   prdata[INT_W-1:0] <= int_mask;
        REG_OFF_TIME_A: prdata[OFF_W-1:0] <= off_time_network_a;
        REG_OFF_TIME_B: prdata[OFF_W-1:0] <= off_time_network_b;
        REG_STEP_COUNT: prdata[15:0]      <= step_count;
        default:        prdata <= '0;
      endcase
    end
  end

  // Software writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_enable        <= CTRL_ENABLE_RESET;
      int_mask           <= INT_MASK_RESET;
      off_time_network_a <= OFF_TIME_A_INIT;
      off_time_network_b <= OFF_TIME_B_INIT;
    end else if (bus_write) begin
      case (paddr)
        REG_CTRL:       soft_enable        <= pwdata[CTRL_ENABLE_BIT];
        REG_INT_MASK:   int_mask           <= pwdata[INT_W-1:0];
        REG_OFF_TIME_A: off_time_network_a <= pwdata[OFF_W-1:0];
        REG_OFF_TIME_B: off_time_network_b <= pwdata[OFF_W-1:0];
        default: ;
      endcase
    end
  end

  // Step clock edge detect
  assign step_edge = step_clock && !step_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_prev <= 1'b0;
    end else begin
      step_prev <= step_clock;
    end
  end

  always_comb begin
    if (rotation_direction) begin
      next_phase = phase + (step_half ? HALF_INC : FULL_INC);
    end else begin
      next_phase = phase - (step_half ? HALF_INC : FULL_INC);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase      <= PHASE_HOME;
      step_count <= '0;
    end else if (!sequence_reset_n) begin
      phase <= PHASE_HOME;
    end else if (step_edge) begin
      phase      <= next_phase;
      step_count <= step_count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_drive <= 1'b0;
      fault_prev  <= 1'b0;
      off_a_prev  <= 1'b0;
      off_b_prev  <= 1'b0;
    end else begin
      fault_drive <= overcurrent || thermal_fault;
      fault_prev  <= fault_drive;
      off_a_prev  <= off_a;
      off_b_prev  <= off_b;
    end
  end

  assign enable_out = 1'b0;
  assign enable_oe  = fault_drive;

  assign bridge_enable = enable_in && !fault_drive && soft_enable;

  assign {drive_a, drive_b} = phase_drive(phase);

  sps_current_ctrl u_bridge_a (
    .pclk          (pclk),
    .presetn       (presetn),
    .bridge_enable (bridge_enable),
    .drive         (drive_a),
    .decay_slow    (decay_slow),
    .trip          (trip_a),
    .off_time      (off_time_network_a),
    .gate          (gate_a),
    .off_active    (off_a)
  );

  sps_current_ctrl u_bridge_b (
    .pclk          (pclk),
    .presetn       (presetn),
    .bridge_enable (bridge_enable),
    .drive         (drive_b),
    .decay_slow    (decay_slow),
    .trip          (trip_b),
    .off_time      (off_time_network_b),
    .gate          (gate_b),
    .off_active    (off_b)
  );

  // Sticky interrupt status, set wins over write-one-clear
  always_comb begin
    int_event                = '0;
    int_event[INT_STEP_BIT]  = step_edge && sequence_reset_n;
    int_event[INT_FAULT_BIT] = fault_drive && !fault_prev;
    int_event[INT_TRIP_A]    = off_a && !off_a_prev;
    int_event[INT_TRIP_B]    = off_b && !off_b_prev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= '0;
    end else if (bus_write && paddr == REG_INT_STATUS) begin
      int_status <= (int_status & ~pwdata[INT_W-1:0]) | int_event;
    end else begin
      int_status <= int_status | int_event;
    end
  end

  assign irq = |(int_status & int_mask);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_step_on_rise: assert property (
    step_edge && sequence_reset_n |=> phase != $past(phase))
    else $error("phase did not advance on step edge");

  a_hold_no_edge: assert property (
    !step_edge && sequence_reset_n |=> phase == $past(phase))
    else $error("phase moved without rising edge");

  a_dir_cw_half: assert property (
    step_edge && sequence_reset_n && rotation_direction && step_half
    |=> phase == 3'($past(phase) + HALF_INC))
    else $error("clockwise half step wrong");

  a_dir_ccw_half: assert property (
    step_edge && sequence_reset_n && !rotation_direction && step_half
    |=> phase == 3'($past(phase) - HALF_INC))
    else $error("counterclockwise half step wrong");

  a_full_step: assert property (
    step_edge && sequence_reset_n && rotation_direction && !step_half
    |=> phase == 3'($past(phase) + FULL_INC))
    else $error("full step size wrong");

  a_enable_off: assert property (
    !enable_in |=> gate_a == GATE_NONE && gate_b == GATE_NONE)
    else $error("bridge driven while enable low");

  a_reset_home: assert property (
    !sequence_reset_n ##1 !sequence_reset_n |-> phase == PHASE_HOME)
    else $error("phase not home during reset");

  a_fault_pull: assert property (
    overcurrent || thermal_fault |=> enable_oe && !enable_out ##1 gate_a == GATE_NONE)
    else $error("fault did not pull enable low");

  a_release_step: assert property (
    $rose(sequence_reset_n) && step_edge && rotation_direction && step_half
    |=> phase == 3'(PHASE_HOME + HALF_INC))
    else $error("first edge after release misstepped");

  a_release_later: assert property (
    !sequence_reset_n ##1 (sequence_reset_n && !step_edge)
    ##1 (step_edge && rotation_direction && step_half)
    |=> phase == 3'(PHASE_HOME + HALF_INC))
    else $error("release then edge misstepped");

  a_count_frozen: assert property (
    !sequence_reset_n |=> step_count == $past(step_count))
    else $error("step counted during sequence reset");

  a_ccw_full: assert property (
    step_edge && sequence_reset_n && !rotation_direction && !step_half
    |=> phase == 3'($past(phase) - FULL_INC))
    else $error("counterclockwise full step wrong");

  a_step_sticky: assert property (
    step_edge && sequence_reset_n |=> int_status[INT_STEP_BIT])
    else $error("step interrupt not set");

  a_count_steady: assert property (
    !step_edge |=> step_count == $past(step_count))
    else $error("step count moved without edge");

  a_fault_sticky: assert property (
    fault_drive && !fault_prev |=> int_status[INT_FAULT_BIT])
    else $error("fault interrupt not set");

  a_trip_sticky: assert property (
    off_a && !off_a_prev |=> int_status[INT_TRIP_A])
    else $error("trip interrupt not set");

  a_soft_off: assert property (
    !soft_enable |=> gate_a == GATE_NONE && gate_b == GATE_NONE)
    else $error("bridge driven while soft disabled");

  c_full_cycle_cw: cover property (
    step_edge && sequence_reset_n && rotation_direction && phase == 3'h7);
  c_trip_slow_a: cover property (off_a && decay_slow);
  c_trip_fast_b: cover property (off_b && !decay_slow);
  c_fault_irq: cover property (fault_drive ##1 irq);
  c_release_step: cover property (!sequence_reset_n ##1 sequence_reset_n ##1 step_edge);

endmodule

// ---- test/sps_motion_ctrl.sv ----
// Motion controller model driving the step, mode and enable pins.
// Assumes the bench calls its tasks; the shared enable wire is resolved here.
`timescale 1ns/1ps
module sps_motion_ctrl (
  input  wire logic pclk,
  input  wire logic enable_out,
  input  wire logic enable_oe,
  output logic      step_clock,
  output logic      rotation_direction,
  output logic      step_half,
  output logic      decay_slow,
  output logic      sequence_reset_n,
  output logic      enable_in
);
  logic drive_en;

  // mode pins start at a fixed level until drive changes them
  initial begin
    step_clock = 1'b0;
    rotation_direction = 1'b0;
    step_half = 1'b0;
    decay_slow = 1'b1;
    sequence_reset_n = 1'b1;
    drive_en = 1'b1;
  end

  // device pull beats the series resistor
  assign enable_in = enable_oe ? enable_out : drive_en;

  task automatic drive(input logic dir, input logic half, input logic slow,
                       input logic rst_n, input logic en);
    @(posedge pclk);
    rotation_direction <= dir;
    step_half <= half;
    decay_slow <= slow;
    sequence_reset_n <= rst_n;
    drive_en <= en;
  endtask

  // one rise per step, low between rises
  task automatic step(input int hi, input int lo);
    @(posedge pclk);
    step_clock <= 1'b1;
    repeat (hi) @(posedge pclk);
    step_clock <= 1'b0;
    repeat (lo) @(posedge pclk);
  endtask
endmodule

// ---- test/stepper_phase_sequencer_inputs_tb.sv ----
// Self-checking bench of the stepper phase sequencer.
// Assumes the motion controller model drives the step and mode pins.
`timescale 1ns/1ps
module stepper_phase_sequencer_inputs_tb import sps_pkg::*;;
  localparam logic [15:0] OFF_A = 16'h0004;
  localparam logic [15:0] OFF_B = 16'h0006;
  // Gate patterns by phase index, index 0 in the low nibble
  localparam logic [31:0] GA = {GATE_POS, GATE_POS, GATE_NONE, GATE_NEG,
                                GATE_NEG, GATE_NEG, GATE_NONE, GATE_POS};
  localparam logic [31:0] GB = {GATE_NONE, GATE_NEG, GATE_NEG, GATE_NEG,
                                GATE_NONE, GATE_POS, GATE_POS, GATE_POS};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        step_clock, rotation_direction, step_half, decay_slow, sequence_reset_n;
  logic        enable_in, enable_out, enable_oe, overcurrent, thermal_fault, trip_a, trip_b;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  gate_a, gate_b;
  logic [2:0]  ph;
  int          num_errors, tests_run, steps;

  sps_sequencer #(.OFF_TIME_A_INIT(OFF_A), .OFF_TIME_B_INIT(OFF_B)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .step_clock, .rotation_direction, .step_half, .decay_slow,
    .sequence_reset_n, .enable_in, .enable_out, .enable_oe, .overcurrent,
    .thermal_fault, .trip_a, .trip_b, .gate_a, .gate_b, .irq);

  sps_motion_ctrl m (
    .pclk, .enable_out, .enable_oe, .step_clock, .rotation_direction, .step_half,
    .decay_slow, .sequence_reset_n, .enable_in);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [7:0] gx(input logic [2:0] p);
    return {GA[p*4+:4], GB[p*4+:4]};
  endfunction

  function automatic logic [2:0] nxt(input logic [2:0] p, input logic d, input logic h);
    return d ? p + (h ? HALF_INC : FULL_INC) : p - (h ? HALF_INC : FULL_INC);
  endfunction

  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 64);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end else begin
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic stp(input int hi, input int lo);
    m.step(hi, lo);
    ph = nxt(ph, rotation_direction, step_half);
    steps++;
  endtask

  task automatic chop(input logic b, input logic [3:0] pat, input logic [15:0] len);
    int c;
    c = 0;
    @(posedge pclk);
    trip_a <= !b;
    trip_b <= b;
    @(posedge pclk);
    trip_a <= 1'b0;
    trip_b <= 1'b0;
    repeat (3 * len) begin
      @(posedge pclk);
      c += ((b ? gate_b : gate_a) === pat);
    end
    chk("off_cycles", {16'h0, len}, c);
    chk("gates_on", gx(3'h0), {gate_a, gate_b});
  endtask

  initial begin
    {presetn, psel, penable, pwrite, overcurrent, thermal_fault, trip_a, trip_b} = '0;
    paddr = '0;
    pwdata = '0;
    num_errors = 0;
    tests_run = 0;
    steps = 0;
    ph = 3'h0;
    void'($urandom(32'hD38F));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, '0);
    chk("ctrl", 32'h1, q);
    apb(1'b0, REG_OFF_TIME_A, '0);
    chk("off_a", {16'h0, OFF_A}, q);
    apb(1'b0, REG_OFF_TIME_B, '0);
    chk("off_b", {16'h0, OFF_B}, q);
    apb(1'b0, REG_STATE, '0);
    chk("home", 32'h0, q[2:0]);
    chk("gates_home", gx(3'h0), {gate_a, gate_b});
    apb(1'b0, 8'h1C, '0);
    chk("unmapped_data", 32'h0, q);
    chk("unmapped_err", 32'h1, err);
    // Slow decay on A, fast on B, each with its own off time
    chop(1'b0, GATE_SLOW, OFF_A);
    m.drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    chop(1'b1, GATE_NEG, OFF_B);
    apb(1'b1, REG_INT_STATUS, 32'hF);
    stp(1, 1);
    apb(1'b0, REG_INT_STATUS, '0);
    chk("step_int", 32'h2, {q[0], irq});
    apb(1'b1, REG_INT_MASK, 32'h1);
    @(posedge pclk);
    chk("irq_on", 32'h1, irq);
    apb(1'b1, REG_INT_STATUS, 32'h1);
    @(posedge pclk);
    chk("irq_off", 32'h0, irq);
    for (int k = 0; k < 40; k++) begin
      m.drive(1'($urandom), 1'($urandom), 1'($urandom), 1'b1, 1'b1);
      stp(1 + $urandom % 3, 1 + $urandom % 3);
      apb(1'b0, REG_STATE, '0);
      chk("state", {decay_slow, step_half, rotation_direction, ph}, {q[9:7], q[2:0]});
      chk("gates", gx(ph), {gate_a, gate_b});
    end
    m.drive(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    repeat (2) @(posedge pclk);
    m.step(1, 1);
    m.step(3, 2);
    apb(1'b0, REG_STATE, '0);
    chk("held_home", 32'h0, q[2:0]);
    m.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    ph = 3'h0;
    stp(1, 1);
    apb(1'b0, REG_STATE, '0);
    chk("first_step", ph, q[2:0]);
    apb(1'b1, REG_STEP_COUNT, 32'hFFFF);
    apb(1'b0, REG_STEP_COUNT, '0);
    chk("count", steps, q);
    m.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    chk("pin_off", 32'h0, {gate_a, gate_b});
    apb(1'b1, REG_CTRL, 32'h0);
    m.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge pclk);
    chk("soft_off", 32'h0, {gate_a, gate_b});
    apb(1'b1, REG_CTRL, 32'h1);
    for (int f = 0; f < 2; f++) begin
      overcurrent <= (f == 0);
      thermal_fault <= (f == 1);
      repeat (4) @(posedge pclk);
      chk("fault_pull", 32'h200, {enable_oe, enable_in, gate_a, gate_b});
      overcurrent <= 1'b0;
      thermal_fault <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("fault_free", {2'b01, gx(ph)}, {enable_oe, enable_in, gate_a, gate_b});
    end
    apb(1'b0, REG_INT_STATUS, '0);
    chk("fault_int", 32'h1, q[1]);
    wrap_up();
  end
endmodule
